/* File: rtl/irq_ctrl_pkg.sv */
// constants, tables and carrier types of the two-level interrupt controller
// assumes one clock domain and an AXI4-Lite master with 32-bit data
package irq_ctrl_pkg;

    localparam int NUM_SRC = 14;

    // register byte offsets
    localparam logic [7:0] OFF_INT_ENABLE      = 8'h00;
    localparam logic [7:0] OFF_EXT_INT_ENABLE  = 8'h04;
    localparam logic [7:0] OFF_INT_PRIORITY    = 8'h08;
    localparam logic [7:0] OFF_EXT_INT_PRIO    = 8'h0c;
    localparam logic [7:0] OFF_PENDING         = 8'h10;
    localparam logic [7:0] OFF_SERVICE_STATE   = 8'h14;
    localparam logic [7:0] OFF_EVENT_STATUS    = 8'h18;
    localparam logic [7:0] OFF_EVENT_MASK      = 8'h1c;

    // field positions
    localparam int GIE_BIT       = 7;
    localparam int LOW_SRC_COUNT = 7;
    localparam int EXT_RSVD_BIT  = 1;
    localparam int EV_TAKEN      = 0;
    localparam int EV_RETURN     = 1;
    localparam int EV_PREEMPT    = 2;
    localparam int NUM_EV        = 3;

    // reset values
    localparam logic [7:0]         REG8_RESET  = 8'h00;
    localparam logic [NUM_SRC-1:0] SRC_RESET   = 14'h0000;
    localparam logic [NUM_EV-1:0]  EV_RESET    = 3'h0;

    // sources whose pending flag clears when the call is made
    localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 14'h000f;

    // timing in clock cycles
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES   = 4;
    localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

    // per-source vector address and tie-break rank (lower rank wins)
    localparam logic [15:0] VECTOR_TABLE [NUM_SRC] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0033,
        16'h003b, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h0073};
    localparam logic [3:0] RANK_TABLE [NUM_SRC] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
        4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SEQ_RUN  = 2'b01,
        SEQ_CALL = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic        start;
        logic        busy;
        logic [15:0] vector;
        logic        level;
    } call_t;

endpackage : irq_ctrl_pkg

/* File: rtl/irq_ctrl.sv */
// two-level interrupt controller: pending flags, enables, priority, long-call sequencing
// assumes the cpu pulses instr_done at each instruction end and return_from_interrupt_done at a return,
// and issues no instr_done while call.busy is high
//
// Contract
// - fourteen sources, each placed at low or high level.
// - a source event sets its pending flag regardless of enable.
// - enabled pending source makes a long call after the current instruction.
// - return resumes the interrupted program and restores the active level.
// - pending flags of disabled sources never raise a request.
// - per-source enable bits work only while the global enable is one.
// - a cleared enable still lets a call through at an instruction end in the one cycle after the write, whatever the instruction length.
// - a cleared enable reads zero even if an interrupt slipped through.
// - some flags clear at vectoring, others stay until software clears.
// - a flag still set after return re-enters after one more instruction.
// - software setting a pending flag acts like a hardware event.
// - high level preempts a low routine; a high routine is never preempted.
// - each source has a priority bit, low after reset.
// - higher level wins; equal levels use a fixed source ranking.
// - requests sampled every clock; fastest response is five cycles.
// - equal or lower requests wait past the return and one instruction.
`timescale 1ns/1ps

module irq_ctrl
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset,
    // register bus
    input  wire axil_req_t          axil_req,
    output axil_rsp_t               axil_rsp,
    // peripheral events
    input  wire logic [NUM_SRC-1:0] src_event,
    // cpu sequencer
    input  wire logic               instr_done,
    input  wire logic               return_from_interrupt_done,
    output call_t                   call,
    // interrupt to system
    output logic                    irq
);

    // register state
    logic                 gie_q, gie_d;
    logic [NUM_SRC-1:0]   en_q, en_d;
    logic [NUM_SRC-1:0]   prio_q, prio_d;
    logic [NUM_SRC-1:0]   pend_q, pend_d;
    logic [NUM_EV-1:0]    ev_stat_q, ev_stat_d;
    logic [NUM_EV-1:0]    ev_mask_q, ev_mask_d;
    logic                 irq_q, irq_d;

    // request and service state
    logic [NUM_SRC-1:0]   req_q, req_d;
    logic [1:0]           active_q, active_d;
    logic                 block_q, block_d;
    seq_state_t           st_q, st_d;
    logic [2:0]           cnt_q, cnt_d;
    call_t                call_q, call_d;

    // bus state
    axil_rsp_t            rsp_q, rsp_d;

    // winner selection
    logic                 win_valid;
    logic                 win_level;
    logic [3:0]           win_src;
    logic [3:0]           win_rank;
    logic                 take;
    logic [NUM_SRC-1:0]   auto_clr;
    logic [NUM_EV-1:0]    ev_set;

    // write and read decode
    logic                 wr_fire;
    logic                 rd_fire;
    logic [7:0]           wbyte;
    logic [31:0]          rd_data;
    logic                 rd_hit;
    logic                 wr_hit;

    assign wr_fire = axil_req.awvalid && axil_req.wvalid && !rsp_q.awready
                     && !rsp_q.bvalid;
    assign rd_fire = axil_req.arvalid && !rsp_q.arready && !rsp_q.rvalid;
    assign wbyte   = axil_req.wstrb[0] ? axil_req.wdata[7:0] : 8'h00;

    // priority decode over the detected requests
    always_comb
    begin
        win_valid = 1'b0;
        win_level = 1'b0;
        win_src   = 4'h0;
        win_rank  = 4'hf;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (req_q[i])
            begin
                if (!win_valid || (prio_q[i] && !win_level)
                    || (prio_q[i] == win_level && RANK_TABLE[i] < win_rank))
                begin
                    win_valid = 1'b1;
                    win_level = prio_q[i];
                    win_src   = 4'(i);
                    win_rank  = RANK_TABLE[i];
                end
            end
        end
    end

    // call only at an instruction end; the first one after a return may take
    always_comb
    begin
        take = 1'b0;
        if (st_q == SEQ_RUN && instr_done && !return_from_interrupt_done && win_valid)
        begin
            if (win_level)
                take = !active_q[1];
            else
                take = !active_q[0] && !active_q[1];
        end
        auto_clr = '0;
        if (take)
            auto_clr[win_src] = HW_CLEAR_MASK[win_src];
    end

    // register file next state
    always_comb
    begin
        gie_d     = gie_q;
        en_d      = en_q;
        prio_d    = prio_q;
        pend_d    = pend_q & ~auto_clr;
        ev_mask_d = ev_mask_q;
        ev_set    = '0;
        ev_set[EV_TAKEN]   = take;
        ev_set[EV_RETURN]  = return_from_interrupt_done && (active_q != 2'b00);
        ev_set[EV_PREEMPT] = take && active_q[0];
        ev_stat_d = ev_stat_q;
        wr_hit    = 1'b0;
        if (wr_fire)
        begin
            wr_hit = 1'b1;
            unique case (axil_req.awaddr)
                OFF_INT_ENABLE:
                begin
                    gie_d = wbyte[GIE_BIT];
                    en_d[LOW_SRC_COUNT-1:0] = wbyte[LOW_SRC_COUNT-1:0];
                end
                OFF_EXT_INT_ENABLE:
                    en_d[NUM_SRC-1:LOW_SRC_COUNT] = {wbyte[7:2], wbyte[0]};
                OFF_INT_PRIORITY:
                    prio_d[LOW_SRC_COUNT-1:0] = wbyte[LOW_SRC_COUNT-1:0];
                OFF_EXT_INT_PRIO:
                    prio_d[NUM_SRC-1:LOW_SRC_COUNT] = {wbyte[7:2], wbyte[0]};
                OFF_PENDING:
                    pend_d = axil_req.wstrb[1:0] == 2'b11 ? axil_req.wdata[NUM_SRC-1:0]
                           : pend_d;
                OFF_EVENT_STATUS:
                    ev_stat_d = ev_stat_q & ~axil_req.wdata[NUM_EV-1:0];
                OFF_EVENT_MASK:
                    ev_mask_d = axil_req.wdata[NUM_EV-1:0];
                default:
                    wr_hit = 1'b0;
            endcase
        end
        pend_d    = pend_d | src_event;
        ev_stat_d = ev_stat_d | ev_set;
        irq_d     = |(ev_stat_d & ev_mask_d);
    end

    // detect stage and service sequencer next state
    always_comb
    begin
        req_d    = pend_q & en_q & {NUM_SRC{gie_q}};
        active_d = active_q;
        block_d  = block_q;
        st_d     = st_q;
        cnt_d    = cnt_q;
        call_d   = call_q;
        call_d.start = 1'b0;
        if (return_from_interrupt_done)
        begin
            if (active_q[1])
                active_d[1] = 1'b0;
            else
                active_d[0] = 1'b0;
            block_d = 1'b1;
        end
        else if (instr_done)
        begin
            block_d = 1'b0;
        end
        unique case (st_q)
            SEQ_RUN:
            begin
                if (take)
                begin
                    active_d[win_level] = 1'b1;
                    call_d.start  = 1'b1;
                    call_d.busy   = 1'b1;
                    call_d.vector = VECTOR_TABLE[win_src];
                    call_d.level  = win_level;
                    cnt_d         = 3'h0;
                    st_d          = SEQ_CALL;
                end
            end
            SEQ_CALL:
            begin
                if (cnt_q == CALL_LAST)
                begin
                    call_d.busy = 1'b0;
                    st_d        = SEQ_RUN;
                end
                else
                begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
        endcase
    end

    // read mux; enable bits read as stored so a cleared enable shows zero
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (axil_req.araddr)
            OFF_INT_ENABLE:
                rd_data[7:0] = {gie_q, en_q[LOW_SRC_COUNT-1:0]};
            OFF_EXT_INT_ENABLE:
                rd_data[7:0] = {en_q[NUM_SRC-1:LOW_SRC_COUNT+1], 1'b0, en_q[LOW_SRC_COUNT]};
            OFF_INT_PRIORITY:
                rd_data[7:0] = {1'b0, prio_q[LOW_SRC_COUNT-1:0]};
            OFF_EXT_INT_PRIO:
                rd_data[7:0] = {prio_q[NUM_SRC-1:LOW_SRC_COUNT+1], 1'b0,
                                prio_q[LOW_SRC_COUNT]};
            OFF_PENDING:
                rd_data[NUM_SRC-1:0] = pend_q;
            OFF_SERVICE_STATE:
                rd_data[5:0] = {call_q.busy, block_q, active_q, 2'(DETECT_CYCLES)};
            OFF_EVENT_STATUS:
                rd_data[NUM_EV-1:0] = ev_stat_q;
            OFF_EVENT_MASK:
                rd_data[NUM_EV-1:0] = ev_mask_q;
            default:
                rd_hit = 1'b0;
        endcase
    end

    // bus response next state
    always_comb
    begin
        rsp_d         = rsp_q;
        rsp_d.awready = wr_fire;
        rsp_d.wready  = wr_fire;
        rsp_d.arready = rd_fire;
        if (wr_fire)
        begin
            rsp_d.bvalid = 1'b1;
            rsp_d.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rsp_q.bvalid && axil_req.bready)
        begin
            rsp_d.bvalid = 1'b0;
        end
        if (rd_fire)
        begin
            rsp_d.rvalid = 1'b1;
            rsp_d.rdata  = rd_data;
            rsp_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rsp_q.rvalid && axil_req.rready)
        begin
            rsp_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            gie_q     <= 1'b0;
            en_q      <= SRC_RESET;
            prio_q    <= SRC_RESET;
            pend_q    <= SRC_RESET;
            ev_stat_q <= EV_RESET;
            ev_mask_q <= EV_RESET;
            irq_q     <= 1'b0;
            req_q     <= SRC_RESET;
            active_q  <= 2'b00;
            block_q   <= 1'b0;
            st_q      <= SEQ_RUN;
            cnt_q     <= 3'h0;
            call_q    <= '0;
            rsp_q     <= '0;
        end
        else
        begin
            gie_q     <= gie_d;
            en_q      <= en_d;
            prio_q    <= prio_d;
            pend_q    <= pend_d;
            ev_stat_q <= ev_stat_d;
            ev_mask_q <= ev_mask_d;
            irq_q     <= irq_d;
            req_q     <= req_d;
            active_q  <= active_d;
            block_q   <= block_d;
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            call_q    <= call_d;
            rsp_q     <= rsp_d;
        end
    end

    assign axil_rsp = rsp_q;
    assign call     = call_q;
    assign irq      = irq_q;

endmodule : irq_ctrl

/* File: bench/irq_ctrl_assertions.sv */
// concurrent checks on the interrupt controller ports
// assumes one clock domain, bound to every irq_ctrl instance
`timescale 1ns/1ps
module irq_ctrl_checker
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input wire logic      ref_clk,
    input wire logic      reset,
    // register bus
    input wire axil_req_t axil_req,
    input wire axil_rsp_t axil_rsp,
    // cpu link
    input wire logic      instr_done,
    input wire logic      return_from_interrupt_done,
    input wire call_t     call,
    input wire logic      irq
);
    logic ret_q;
    logic ret_d;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // set by a return, cleared by the next instruction end
    always_comb
    begin
        ret_d = ret_q;
        if (return_from_interrupt_done)
            ret_d = 1'b1;
        else if (instr_done)
            ret_d = 1'b0;
    end
    always_ff @(posedge ref_clk)
        ret_q <= reset ? 1'b0 : ret_d;
    a_start_pulse: assert property (call.start |=> !call.start)
        else $error("call start wider than one cycle");
    a_busy_len: assert property (call.start |-> call.busy [*4] ##1 !call.busy)
        else $error("call busy not four cycles");
    a_start_cause: assert property (call.start |-> $past(instr_done) && !$past(call.busy))
        else $error("call without instruction end");
    a_vec_legal: assert property (call.start |-> call.vector[1:0] == 2'b11
        && call.vector <= 16'h0073 && call.vector != 16'h0043)
        else $error("call vector outside table");
    a_vec_hold: assert property (!call.start |-> $stable(call.vector) && $stable(call.level))
        else $error("vector changed without call");
    a_ret_wait: assert property ((return_from_interrupt_done || (ret_q && !instr_done)) |=> !call.start)
        else $error("call too soon after return");
    a_wr_answer: assert property (axil_req.awvalid && axil_req.wvalid && !axil_rsp.bvalid
        && !axil_rsp.awready |=> axil_rsp.awready && axil_rsp.wready && axil_rsp.bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (axil_req.arvalid && !axil_rsp.arready
        && !axil_rsp.rvalid |=> axil_rsp.arready && axil_rsp.rvalid)
        else $error("read not answered");
    c_high_call: cover property (call.start && call.level);
    c_return: cover property (return_from_interrupt_done);
    c_irq: cover property (irq);
endmodule : irq_ctrl_checker
bind irq_ctrl irq_ctrl_checker chk (.ref_clk(ref_clk), .reset(reset), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done), .call(call), .irq(irq));

/* File: bench/cpu_model.sv */
// cpu sequencer model: instructions of gap cycles, returns on request
// assumes call_t from irq_ctrl_pkg and one clock
`timescale 1ns/1ps
module cpu_model
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // controller side
    input  wire call_t      call,
    output logic            instr_done,
    output logic            return_from_interrupt_done,
    // bench control
    input  wire logic [3:0] gap,
    input  wire logic       ret_req
);
    logic [3:0] cnt_q;
    logic [3:0] depth_q;
    logic       ret_q;
    logic       fin;
    // no instruction ends while the call runs
    assign fin        = !reset && !call.busy && cnt_q == 4'h0;
    assign return_from_interrupt_done  = fin && ret_q && depth_q != 4'h0;
    assign instr_done = fin && !return_from_interrupt_done;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_q   <= 4'h0;
            depth_q <= 4'h0;
            ret_q   <= 1'b0;
        end
        else
        begin
            cnt_q   <= (call.busy || fin) ? gap - 4'h1 : cnt_q - 4'h1;
            depth_q <= depth_q + 4'(call.start) - 4'(return_from_interrupt_done);
            ret_q   <= ret_req || (ret_q && !return_from_interrupt_done);
        end
    end
endmodule : cpu_model

/* File: bench/two_level_interrupt_controller_test.sv */
// self-checking bench of irq_ctrl with a cpu model and a bus master
// assumes the offsets and timing of irq_ctrl_pkg
`timescale 1ns/1ps
`define CHK(e, a) begin n_checks++; if ((a) !== (e)) begin \
    $display("BAD t=%0t exp=%h got=%h", $time, e, a); err_total++; end end
module two_level_interrupt_controller_test
    import irq_ctrl_pkg::*;
;
    logic               ref_clk = 1'b0;
    logic               reset = 1'b1;
    axil_req_t          rq = '0;
    axil_rsp_t          rsp;
    logic [NUM_SRC-1:0] ev = '0;
    logic               instr_done;
    logic               return_from_interrupt_done;
    logic               irq;
    logic               ret_req = 1'b0;
    logic [3:0]         gap = 4'h1;
    call_t              call;
    logic [16:0]        ec;
    logic [33:0]        er;
    logic [16:0]        exp_call[$];
    logic [33:0]        exp_rd[$];
    int                 err_total = 0;
    int                 n_checks = 0;
    int                 seed = 7;
    int                 k;
    int                 i;
    always #25 ref_clk = ~ref_clk;
    irq_ctrl uut (.ref_clk(ref_clk), .reset(reset), .axil_req(rq), .axil_rsp(rsp),
        .src_event(ev), .instr_done(instr_done), .return_from_interrupt_done(return_from_interrupt_done), .call(call), .irq(irq));
    cpu_model cpu (.ref_clk(ref_clk), .reset(reset), .call(call), .instr_done(instr_done),
        .return_from_interrupt_done(return_from_interrupt_done), .gap(gap), .ret_req(ret_req));
    task automatic results;
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic tmo(input int n);
        if (n >= 200)
        begin
            err_total++;
            results();
        end
    endtask : tmo
    // one write or one read; the read result is checked by the watcher
    task automatic bus(input logic w, input logic [7:0] a, input logic [33:0] d);
        int n;
        n = 0;
        if (!w)
            exp_rd.push_back(d);
        @(posedge ref_clk);
        rq.awaddr  <= a;
        rq.araddr  <= a;
        rq.wdata   <= d[31:0];
        rq.wstrb   <= 4'hf;
        rq.awvalid <= w;
        rq.wvalid  <= w;
        rq.bready  <= w;
        rq.arvalid <= !w;
        rq.rready  <= !w;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (rsp.awready)
                rq.awvalid <= 1'b0;
            if (rsp.wready)
                rq.wvalid <= 1'b0;
            if (rsp.arready)
                rq.arvalid <= 1'b0;
        end
        while (!(w ? rsp.bvalid : rsp.rvalid) && n < 200);
        rq.bready <= 1'b0;
        rq.rready <= 1'b0;
        tmo(n);
    endtask : bus
    task automatic settle;
        int n;
        n = 0;
        repeat (3) @(posedge ref_clk);
        while ((exp_call.size() != 0 || call.busy) && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
        tmo(n);
    endtask : settle
    task automatic ret;
        int n;
        n = 0;
        @(posedge ref_clk);
        ret_req <= 1'b1;
        @(posedge ref_clk);
        ret_req <= 1'b0;
        while (!return_from_interrupt_done && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
        tmo(n);
        settle();
    endtask : ret
    always @(posedge ref_clk)
    begin
        if (!reset && call.start)
        begin
            ec = exp_call.size() != 0 ? exp_call.pop_front() : 'x;
            `CHK(ec, {call.level, call.vector})
        end
        if (rsp.rvalid && rq.rready)
        begin
            er = exp_rd.size() != 0 ? exp_rd.pop_front() : 'x;
            `CHK(er, {rsp.rresp, rsp.rdata})
        end
        if (rsp.bvalid && rq.bready)
            `CHK(RESP_OKAY, rsp.bresp)
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        for (i = 0; i < 8; i++)
            bus(1'b0, 8'(i * 4), (i == 5) ? 34'h1 : 34'h0);
        bus(1'b0, 8'h20, {RESP_SLVERR, 32'h0});
        k = $unsigned($random(seed)) % NUM_SRC;
        gap <= 4'($unsigned($random(seed)) % 3 + 1);
        ev[k] <= 1'b1;
        @(posedge ref_clk);
        ev <= '0;
        bus(1'b0, OFF_PENDING, 34'(1 << k));
        bus(1'b1, OFF_INT_ENABLE, 34'h7f);
        bus(1'b1, OFF_EXT_INT_ENABLE, 34'hff);
        bus(1'b0, OFF_EXT_INT_ENABLE, 34'hfd);
        bus(1'b1, OFF_EXT_INT_PRIO, 34'hff);
        bus(1'b0, OFF_EXT_INT_PRIO, 34'hfd);
        bus(1'b1, OFF_EXT_INT_PRIO, 34'h0);
        repeat (8) @(posedge ref_clk);
        exp_call.push_back({1'b0, VECTOR_TABLE[k]});
        bus(1'b1, OFF_INT_ENABLE, 34'hff);
        settle();
        bus(1'b0, OFF_PENDING, HW_CLEAR_MASK[k] ? 34'h0 : 34'(1 << k));
        if (!HW_CLEAR_MASK[k])
            exp_call.push_back({1'b0, VECTOR_TABLE[k]});
        ret();
        bus(1'b1, OFF_PENDING, 34'h0);
        if (!HW_CLEAR_MASK[k])
            ret();
        gap <= 4'h1;
        bus(1'b1, OFF_INT_PRIORITY, 34'h20);
        exp_call.push_back({1'b1, VECTOR_TABLE[5]});
        bus(1'b1, OFF_PENDING, 34'h22);
        settle();
        bus(1'b1, OFF_PENDING, 34'h02);
        repeat (8) @(posedge ref_clk);
        exp_call.push_back({1'b0, VECTOR_TABLE[1]});
        ret();
        exp_call.push_back({1'b1, VECTOR_TABLE[5]});
        bus(1'b1, OFF_PENDING, 34'h20);
        settle();
        bus(1'b1, OFF_PENDING, 34'h0);
        ret();
        ret();
        bus(1'b1, OFF_INT_PRIORITY, 34'h0);
        exp_call.push_back({1'b0, VECTOR_TABLE[1]});
        bus(1'b1, OFF_PENDING, 34'h12);
        settle();
        bus(1'b1, OFF_PENDING, 34'h0);
        ret();
        bus(1'b0, OFF_EVENT_STATUS, 34'h7);
        `CHK(1'b0, irq)
        bus(1'b1, OFF_EVENT_MASK, 34'h4);
        repeat (2) @(posedge ref_clk);
        `CHK(1'b1, irq)
        bus(1'b1, OFF_EVENT_STATUS, 34'h4);
        repeat (2) @(posedge ref_clk);
        `CHK(1'b0, irq)
        bus(1'b0, OFF_EVENT_STATUS, 34'h3);
        gap <= 4'h3;
        bus(1'b1, OFF_INT_ENABLE, 34'h7f);
        bus(1'b1, OFF_PENDING, 34'h08);
        repeat (8) @(posedge ref_clk);
        bus(1'b0, OFF_INT_ENABLE, 34'h7f);
        @(posedge ref_clk);
        `CHK(0, exp_call.size() + exp_rd.size())
        results();
    end
endmodule : two_level_interrupt_controller_test
